/* bench/dgp_pin_model.sv */
`timescale 1ns/1ps
`default_nettype none
module dgp_pin_model (
    input  wire logic       clk_in,
    input  wire logic [7:0] a_out_in,
    input  wire logic [7:0] a_oe_in,
    input  wire logic [7:0] a_ext_in,
    input  wire logic [3:0] b_out_in,
    input  wire logic [3:0] b_oe_in,
    input  wire logic [3:0] b_ext_in,
    output logic [7:0]      a_pin_out,
    output logic [3:0]      b_pin_out
);
    logic miso_q = 1'b0;
    logic [3:0] b_res;
    // A deselected memory releases its data line, so it toggles rather than hold a stale level.
    always @(posedge clk_in)
        miso_q <= (b_oe_in[3] && !b_out_in[3]) ? b_ext_in[2] : ~miso_q;
    assign a_pin_out = (a_oe_in & a_out_in) | (~a_oe_in & a_ext_in);
    assign b_res = (b_oe_in & b_out_in) | (~b_oe_in & b_ext_in);
    assign b_pin_out = {b_res[3], miso_q, b_res[1:0]};
endmodule
`default_nettype wire

/* bench/tb_dual_gpio_port_mux.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_dual_gpio_port_mux;
    import dgp_pkg::*;
    logic            clk = 1'b0;
    logic            rst = 1'b1;
    dgp_sfr_req_t    req = '0;
    logic [1:0]      route = 2'h1;
    dgp_periph_out_t per = '0;
    dgp_periph_in_t  pside;
    logic            tick;
    logic [7:0]      rdata, a_out, a_oe, src, snk, a_pin, eoe;
    logic [7:0]      a_ext = 8'h00;
    logic [3:0]      b_out, b_oe, b_pin, boe, bout;
    logic [3:0]      b_ext = 4'h0;
    logic [31:0]     seed = 32'h83D8;
    logic [7:0]      m [7];
    logic [7:0]      addr [7] = '{BANK_A_DATA_ADDR, BANK_B_DATA_ADDR, BANK_A_DRIVE_ADDR,
        BANK_A_DIR_ADDR, BANK_A_ALT_ADDR, BANK_B_DIR_ADDR, BANK_B_ALT_ADDR};
    logic [7:0]      wmask [7] = '{8'hFF, 8'h0F, 8'hFF, 8'hFF, 8'hFF, 8'h0F, 8'h0F};
    logic [7:0]      rst_val [7] = '{8'hFF, 8'h0F, 8'h00, 8'hFF, 8'h00, 8'h04, 8'h00};
    int              bad_count = 0;
    int              checked = 0;

    always #4 clk = ~clk;

    dgp_port_mux i_dut (.SYS_CLK_IN(clk), .SYS_RST_IN(rst), .SFR_REQ_IN(req),
        .SFR_RDATA_OUT(rdata), .SPI_ROUTE_IN(route), .PERIPH_IN(per), .PERIPH_OUT(pside),
        .COUNT_TICK_OUT(tick), .BANK_A_PIN_IN(a_pin), .BANK_A_PIN_OUT(a_out),
        .BANK_A_PIN_OE_OUT(a_oe), .BANK_A_SOURCE_HI_OUT(src), .BANK_A_SINK_HI_OUT(snk),
        .BANK_B_PIN_IN(b_pin), .BANK_B_PIN_OUT(b_out), .BANK_B_PIN_OE_OUT(b_oe));

    dgp_pin_model i_pins (.clk_in(clk), .a_out_in(a_out), .a_oe_in(a_oe), .a_ext_in(a_ext),
        .b_out_in(b_out), .b_oe_in(b_oe), .b_ext_in(b_ext), .a_pin_out(a_pin), .b_pin_out(b_pin));

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    task automatic stop_test();
        $display("checks %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input logic [7:0] msk,
                       input string what);
        checked++;
        if ((got & msk) !== (exp & msk))
        begin
            bad_count++;
            $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        req <= '{1'b1, a, d};
        @(posedge clk);
        req <= '0;
        @(negedge clk);
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        req <= '{1'b0, a, 8'h00};
        @(negedge clk);
        d = rdata;
    endtask

    task automatic check_pins();
        logic [7:0] eout;
        eoe = (m[4] & {1'b1, 4'h0, 1'b1, ~m[3][1], 1'b1}) | (~m[4] & ~m[3]);
        eout = (~m[4] & m[0]) | (m[4] & {per.pwm, 4'h0, per.txd, 1'b0, per.general_timer_output});
        if (route == SPI_ROUTE_BANK_B)
        begin
            boe = {~m[5][3], 3'h3};
            bout = {m[1][3], 1'b0, per.spi_mosi, per.spi_sck};
        end
        else
        begin
            boe = {~m[5][3], 1'b0, ~m[5][1], ~m[6][0] & ~m[5][0]};
            bout = m[1][3:0];
        end
        chk(a_oe, eoe, 8'hFF, "a_oe");
        chk(a_out, eout, eoe & ~{6'h00, m[4][1], 1'b0}, "a_out");
        chk(src, m[2] & 8'hAA, 8'hFF, "source");
        chk(snk, m[2] & 8'h55, 8'hFF, "sink");
        chk({4'h0, b_oe}, {4'h0, boe}, 8'hFF, "b_oe");
        chk({4'h0, b_out}, {4'h0, bout}, {4'h0, boe}, "b_out");
    endtask

    task automatic check_regs();
        logic [7:0] d;
        for (int k = 2; k < 7; k++)
        begin
            rd(addr[k], d);
            chk(d, m[k], 8'hFF, "reg");
        end
    endtask

    task automatic check_inputs();
        logic [7:0] d, ep;
        logic sel, spi;
        sel = boe[3] & ~bout[3];
        spi = (route == SPI_ROUTE_BANK_B);
        rd(BANK_A_DATA_ADDR, d);
        chk(d, a_pin, 8'hFF, "a_read");
        rd(BANK_B_DATA_ADDR, d);
        chk(d, {4'h0, b_pin}, {5'h1F, sel, 2'h3}, "b_read");
        ep = {1'b0, m[4][1] ? a_pin[1] : 1'b1, m[4][3] ? a_pin[3] : 1'b1,
              m[4][4] ? a_pin[4] : 1'b1, m[4][5] & a_pin[5], m[4][6] & a_pin[6],
              ~spi & m[6][0] & b_pin[0], spi & b_pin[2]};
        chk({1'b0, pside}, ep, {7'h7F, sel | ~spi}, "periph");
    endtask

    task automatic check_tick();
        int n;
        n = 0;
        while (tick !== 1'b1 && n < 10)
        begin
            @(negedge clk);
            n++;
        end
        @(negedge clk);
        n = 1;
        while (tick !== 1'b1 && n < 10)
        begin
            @(negedge clk);
            n++;
        end
        chk(8'(n), 8'h04, 8'hFF, "tick");
    endtask

    task automatic do_reset();
        @(posedge clk);
        rst <= 1'b1;
        route <= SPI_ROUTE_BANK_B;
        for (int k = 0; k < 7; k++)
            m[k] = rst_val[k];
        @(negedge clk);
        check_pins();
        @(posedge clk);
        rst <= 1'b0;
    endtask

    initial
    begin
        repeat (20000) @(posedge clk);
        bad_count++;
        $display("unexpected at %0t: run did not finish", $time);
        stop_test();
    end

    initial
    begin
        logic [7:0] d, v;
        do_reset();
        check_regs();
        $display("test reset done");
        wr(8'h91, 8'hA5);
        rd(8'h91, d);
        chk(d, 8'h00, 8'hFF, "unmapped");
        check_regs();
        check_tick();
        $display("test unmapped and tick done");
        for (int i = 0; i < 32; i++)
        begin
            @(posedge clk);
            route <= 2'(i);
            per <= dgp_periph_out_t'(5'(rnd()));
            a_ext <= 8'(rnd());
            b_ext <= 4'(rnd());
            for (int k = 0; k < 7; k++)
            begin
                v = 8'(rnd());
                wr(addr[k], v);
                m[k] = v & wmask[k];
            end
            check_pins();
            check_regs();
            repeat (8) @(negedge clk);
            check_inputs();
        end
        $display("test random modes done");
        do_reset();
        check_regs();
        check_pins();
        $display("test second reset done");
        stop_test();
    end
endmodule
`default_nettype wire

/* rtl/dgp_pkg.sv */
package dgp_pkg;

    // Special function register addresses.
    localparam logic [7:0] BANK_A_DATA_ADDR  = 8'h80;
    localparam logic [7:0] BANK_B_DATA_ADDR  = 8'h90;
    localparam logic [7:0] BANK_A_DRIVE_ADDR = 8'h93;
    localparam logic [7:0] BANK_A_DIR_ADDR   = 8'h94;
    localparam logic [7:0] BANK_A_ALT_ADDR   = 8'h95;
    localparam logic [7:0] BANK_B_DIR_ADDR   = 8'h96;
    localparam logic [7:0] BANK_B_ALT_ADDR   = 8'h97;

    // Reset values.
    localparam logic [7:0] BANK_A_DATA_RST   = 8'hFF;
    localparam logic [3:0] BANK_B_DATA_RST   = 4'hF;
    localparam logic [7:0] BANK_A_DRIVE_RST  = 8'h00;
    localparam logic [7:0] BANK_A_DIR_RST    = 8'hFF;
    localparam logic [7:0] BANK_A_ALT_RST    = 8'h00;
    localparam logic [3:0] BANK_B_DIR_RST    = 4'h4;
    localparam logic [3:0] BANK_B_ALT_RST    = 4'h0;

    // Bank B pin positions.
    localparam int unsigned B_SCK_BIT  = 0;
    localparam int unsigned B_MOSI_BIT = 1;
    localparam int unsigned B_MISO_BIT = 2;
    localparam int unsigned B_SEL_BIT  = 3;

    // Bank A alternate pin positions.
    localparam int unsigned A_TMR_BIT  = 0;
    localparam int unsigned A_RXD_BIT  = 1;
    localparam int unsigned A_TXD_BIT  = 2;
    localparam int unsigned A_IRQA_BIT = 3;
    localparam int unsigned A_IRQB_BIT = 4;
    localparam int unsigned A_CNTA_BIT = 5;
    localparam int unsigned A_CNTB_BIT = 6;
    localparam int unsigned A_PWM_BIT  = 7;

    // Alternate pins that the peripheral drives out.
    localparam logic [7:0] A_ALT_OUT_MASK = 8'h85;

    // Routing field code for SPI on bank B.
    localparam logic [1:0] SPI_ROUTE_BANK_B = 2'h1;

    // Counter inputs are sampled once every this many clocks.
    localparam int unsigned CNT_SAMPLE_DIV = 4;
    localparam logic [1:0]  CNT_DIV_LAST   = 2'(CNT_SAMPLE_DIV - 1);

    typedef struct packed {
        logic       wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } dgp_sfr_req_t;

    typedef struct packed {
        logic general_timer_output;
        logic txd;
        logic pwm;
        logic spi_sck;
        logic spi_mosi;
    } dgp_periph_out_t;

    typedef struct packed {
        logic rxd;
        logic ext_irq_a_n;
        logic ext_irq_b_n;
        logic counter_a_input;
        logic counter_b_input;
        logic counter_c_input;
        logic spi_miso;
    } dgp_periph_in_t;

endpackage

/* rtl/dgp_port_mux.sv */
// Overview of operation
// RULE1: Bank A alt clear: direction 0 out, 1 in.
// RULE2: Bank A alt select overrides direction bit.
// RULE3: Alt pins 0,2,7 out; 3-6 in; 1 by direction.
// RULE4: High drive: odd pins source, even pins sink.
// RULE5: Bank A data bit n maps pin n.
// RULE6: Bank B uses four low register bits.
// RULE7: Routing 01: SCK, MOSI out, MISO in.
// RULE8: Bank B direction overridden by alt or routing.
// RULE9: Outside routing, alt 0 makes SCK counter input.
// RULE10: Outside routing, alt 0 clear: SCK is GPIO.
// RULE11: MOSI and select pins follow direction bits.
// RULE12: MISO is always an input.
// RULE13: Boot select pin is always software GPIO.
// RULE14: Bank B direction 0 output, 1 input.
// RULE15: Bank B comes up as SPI master.
// RULE16: Software may use bank A pins as selects.
// RULE17: Reset: bank A inputs, bank B SPI master.
// RULE18: Routing 00 unused, 01 bank B, 1x internal.
// RULE19: Counter inputs on pins 5,6 sampled every four clocks.
// RULE20: Pin inputs pass two synchronising flip-flops.
// RULE21: Pin drive follows registers, next cycle after write.
`timescale 1ns/1ps
`default_nettype none
module dgp_port_mux
    import dgp_pkg::*;
(
    input  wire logic                     SYS_CLK_IN,
    input  wire logic                     SYS_RST_IN,
    input  wire dgp_pkg::dgp_sfr_req_t    SFR_REQ_IN,
    output logic [7:0]                    SFR_RDATA_OUT,
    input  wire logic [1:0]               SPI_ROUTE_IN,
    input  wire dgp_pkg::dgp_periph_out_t PERIPH_IN,
    output wire dgp_pkg::dgp_periph_in_t  PERIPH_OUT,
    output logic                          COUNT_TICK_OUT,
    input  wire logic [7:0]               BANK_A_PIN_IN,
    output wire logic [7:0]               BANK_A_PIN_OUT,
    output wire logic [7:0]               BANK_A_PIN_OE_OUT,
    output wire logic [7:0]               BANK_A_SOURCE_HI_OUT,
    output wire logic [7:0]               BANK_A_SINK_HI_OUT,
    input  wire logic [3:0]               BANK_B_PIN_IN,
    output logic [3:0]                    BANK_B_PIN_OUT,
    output logic [3:0]                    BANK_B_PIN_OE_OUT
);
    import dgp_pkg::*;

    logic [7:0] a_data_q;
    logic [7:0] a_drive_q;
    logic [7:0] a_dir_q;
    logic [7:0] a_alt_q;
    logic [3:0] b_data_q;
    logic [3:0] b_dir_q;
    logic [3:0] b_alt_q;

    logic [7:0] a_sync;
    logic [3:0] b_sync;
    logic       tick;

    // Write decode.
    wire wr_a_data  = SFR_REQ_IN.wr && (SFR_REQ_IN.addr == BANK_A_DATA_ADDR);
    wire wr_a_drive = SFR_REQ_IN.wr && (SFR_REQ_IN.addr == BANK_A_DRIVE_ADDR);
    wire wr_a_dir   = SFR_REQ_IN.wr && (SFR_REQ_IN.addr == BANK_A_DIR_ADDR);
    wire wr_a_alt   = SFR_REQ_IN.wr && (SFR_REQ_IN.addr == BANK_A_ALT_ADDR);
    wire wr_b_data  = SFR_REQ_IN.wr && (SFR_REQ_IN.addr == BANK_B_DATA_ADDR);
    wire wr_b_dir   = SFR_REQ_IN.wr && (SFR_REQ_IN.addr == BANK_B_DIR_ADDR);
    wire wr_b_alt   = SFR_REQ_IN.wr && (SFR_REQ_IN.addr == BANK_B_ALT_ADDR);

    // Registers load on the write edge, so pins change one cycle later.
    always_ff @(posedge SYS_CLK_IN or posedge SYS_RST_IN)
    begin
        if (SYS_RST_IN)
        begin
            a_data_q  <= BANK_A_DATA_RST;
            a_drive_q <= BANK_A_DRIVE_RST;
            a_dir_q   <= BANK_A_DIR_RST; // RULE17
            a_alt_q   <= BANK_A_ALT_RST;
            b_data_q  <= BANK_B_DATA_RST;
            b_dir_q   <= BANK_B_DIR_RST; // RULE15
            b_alt_q   <= BANK_B_ALT_RST;
        end
        else
        begin
            if (wr_a_data)  a_data_q  <= SFR_REQ_IN.wdata; // RULE5
            if (wr_a_drive) a_drive_q <= SFR_REQ_IN.wdata;
            if (wr_a_dir)   a_dir_q   <= SFR_REQ_IN.wdata; // RULE21
            if (wr_a_alt)   a_alt_q   <= SFR_REQ_IN.wdata; // RULE21
            if (wr_b_data)  b_data_q  <= SFR_REQ_IN.wdata[3:0]; // RULE6
            if (wr_b_dir)   b_dir_q   <= SFR_REQ_IN.wdata[3:0]; // RULE6
            if (wr_b_alt)   b_alt_q   <= SFR_REQ_IN.wdata[3:0]; // RULE6
        end
    end

    dgp_sync #(.WIDTH(8)) u_sync_a ( // RULE20
        .clk_in   (SYS_CLK_IN),
        .rst_in   (SYS_RST_IN),
        .async_in (BANK_A_PIN_IN),
        .sync_out (a_sync)
    );

    dgp_sync #(.WIDTH(4)) u_sync_b ( // RULE20
        .clk_in   (SYS_CLK_IN),
        .rst_in   (SYS_RST_IN),
        .async_in (BANK_B_PIN_IN),
        .sync_out (b_sync)
    );

    dgp_strobe u_strobe (
        .clk_in   (SYS_CLK_IN),
        .rst_in   (SYS_RST_IN),
        .tick_out (tick)
    );

    assign COUNT_TICK_OUT = tick;

    // Bank A: alternate output values and output enables per pin.
    wire [7:0] a_alt_val = {PERIPH_IN.pwm, 4'h0, PERIPH_IN.txd, 1'b0,
                            PERIPH_IN.general_timer_output};
    // Receive pin direction stays with software even in alternate mode.
    wire [7:0] a_alt_oe  = A_ALT_OUT_MASK | {6'h00, ~a_dir_q[A_RXD_BIT], 1'b0}; // RULE3
    wire [7:0] a_gpio_oe = ~a_dir_q; // RULE1

    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++)
        begin : g_bank_a
            assign BANK_A_PIN_OE_OUT[gi] = a_alt_q[gi] ? a_alt_oe[gi] : a_gpio_oe[gi]; // RULE2
            assign BANK_A_PIN_OUT[gi]    = a_alt_q[gi] ? a_alt_val[gi] : a_data_q[gi];
            // Odd pins get the strong pull-up, even pins the strong pull-down.
            if (gi % 2 == 1)
            begin : g_odd
                assign BANK_A_SOURCE_HI_OUT[gi] = a_drive_q[gi]; // RULE4
                assign BANK_A_SINK_HI_OUT[gi]   = 1'b0;
            end
            else
            begin : g_even
                assign BANK_A_SOURCE_HI_OUT[gi] = 1'b0;
                assign BANK_A_SINK_HI_OUT[gi]   = a_drive_q[gi]; // RULE4
            end
        end
    endgenerate

    // Bank B routing.
    wire spi_mode  = (SPI_ROUTE_IN == SPI_ROUTE_BANK_B); // RULE18
    wire sck_count = !spi_mode && b_alt_q[B_SCK_BIT]; // RULE9

    wire [3:0] b_gpio_oe = ~b_dir_q; // RULE14
    wire       sck_oe    = spi_mode ? 1'b1 : (!sck_count && b_gpio_oe[B_SCK_BIT]); // RULE8 RULE10
    wire       mosi_oe   = spi_mode ? 1'b1 : b_gpio_oe[B_MOSI_BIT]; // RULE7 RULE11
    wire       sel_oe    = b_gpio_oe[B_SEL_BIT]; // RULE11 RULE13

    assign BANK_B_PIN_OE_OUT = {sel_oe, 1'b0, mosi_oe, sck_oe}; // RULE12
    assign BANK_B_PIN_OUT    = {b_data_q[B_SEL_BIT], b_data_q[B_MISO_BIT],
                                spi_mode ? PERIPH_IN.spi_mosi : b_data_q[B_MOSI_BIT],
                                spi_mode ? PERIPH_IN.spi_sck : b_data_q[B_SCK_BIT]}; // RULE7

    // Counter inputs are held between ticks so the counters see one sample per period.
    logic cnt_a_q;
    logic cnt_b_q;
    logic cnt_c_q;

    always_ff @(posedge SYS_CLK_IN or posedge SYS_RST_IN)
    begin
        if (SYS_RST_IN)
        begin
            cnt_a_q <= 1'b0;
            cnt_b_q <= 1'b0;
            cnt_c_q <= 1'b0;
        end
        else if (tick)
        begin
            cnt_a_q <= a_alt_q[A_CNTA_BIT] & a_sync[A_CNTA_BIT]; // RULE19
            cnt_b_q <= a_alt_q[A_CNTB_BIT] & a_sync[A_CNTB_BIT]; // RULE19
            cnt_c_q <= sck_count & b_sync[B_SCK_BIT]; // RULE9
        end
    end

    // Interrupt inputs are active low, so an unselected pin reads as idle high.
    assign PERIPH_OUT.rxd             = a_alt_q[A_RXD_BIT] ? a_sync[A_RXD_BIT] : 1'b1;
    assign PERIPH_OUT.ext_irq_a_n     = a_alt_q[A_IRQA_BIT] ? a_sync[A_IRQA_BIT] : 1'b1;
    assign PERIPH_OUT.ext_irq_b_n     = a_alt_q[A_IRQB_BIT] ? a_sync[A_IRQB_BIT] : 1'b1;
    assign PERIPH_OUT.counter_a_input = cnt_a_q;
    assign PERIPH_OUT.counter_b_input = cnt_b_q;
    assign PERIPH_OUT.counter_c_input = cnt_c_q;
    assign PERIPH_OUT.spi_miso        = spi_mode ? b_sync[B_MISO_BIT] : 1'b0;

    // Data registers read back the synchronised pin levels, as on a classic port.
    always_comb
    begin
        SFR_RDATA_OUT = 8'h00;
        unique case (SFR_REQ_IN.addr)
            BANK_A_DATA_ADDR:  SFR_RDATA_OUT = a_sync; // RULE5
            BANK_B_DATA_ADDR:  SFR_RDATA_OUT = {4'h0, b_sync};
            BANK_A_DRIVE_ADDR: SFR_RDATA_OUT = a_drive_q;
            BANK_A_DIR_ADDR:   SFR_RDATA_OUT = a_dir_q;
            BANK_A_ALT_ADDR:   SFR_RDATA_OUT = a_alt_q;
            BANK_B_DIR_ADDR:   SFR_RDATA_OUT = {4'h0, b_dir_q};
            BANK_B_ALT_ADDR:   SFR_RDATA_OUT = {4'h0, b_alt_q};
            default:           SFR_RDATA_OUT = 8'h00;
        endcase
    end

    AST_A_GPIO_DIR: assert property (@(posedge SYS_CLK_IN) disable iff (SYS_RST_IN) // RULE1
        !a_alt_q[4] |-> (BANK_A_PIN_OE_OUT[4] == !a_dir_q[4]))
        else $error("bank A gpio direction wrong");

    AST_A_ALT_PRIO: assert property (@(posedge SYS_CLK_IN) disable iff (SYS_RST_IN) // RULE2
        a_alt_q[7] |-> BANK_A_PIN_OE_OUT[7] && BANK_A_PIN_OUT[7] == PERIPH_IN.pwm)
        else $error("alternate select did not win");

    AST_A_ALT_IN: assert property (@(posedge SYS_CLK_IN) disable iff (SYS_RST_IN) // RULE3
        a_alt_q[5] |-> !BANK_A_PIN_OE_OUT[5] && !BANK_A_PIN_OE_OUT[3] || !a_alt_q[3])
        else $error("alternate input pin driven");

    AST_DRIVE: assert property (@(posedge SYS_CLK_IN) disable iff (SYS_RST_IN) // RULE4
        BANK_A_SOURCE_HI_OUT[1] == a_drive_q[1] && !BANK_A_SOURCE_HI_OUT[0]
        && BANK_A_SINK_HI_OUT[0] == a_drive_q[0])
        else $error("high drive polarity wrong");

    AST_SPI_MASTER: assert property (@(posedge SYS_CLK_IN) disable iff (SYS_RST_IN) // RULE7
        spi_mode |-> BANK_B_PIN_OE_OUT[2:0] == 3'h3 && BANK_B_PIN_OUT[0] == PERIPH_IN.spi_sck)
        else $error("spi master routing wrong");

    AST_SCK_COUNT: assert property (@(posedge SYS_CLK_IN) disable iff (SYS_RST_IN) // RULE9
        !spi_mode && b_alt_q[0] |-> !BANK_B_PIN_OE_OUT[0])
        else $error("sck driven while counter input");

    AST_MISO_IN: assert property (@(posedge SYS_CLK_IN) disable iff (SYS_RST_IN) // RULE12
        !BANK_B_PIN_OE_OUT[2])
        else $error("miso driven");

    AST_SEL_GPIO: assert property (@(posedge SYS_CLK_IN) disable iff (SYS_RST_IN) // RULE13
        BANK_B_PIN_OE_OUT[3] == !b_dir_q[3] && BANK_B_PIN_OUT[3] == b_data_q[3])
        else $error("boot select not gpio");

    AST_WR_EFFECT: assert property (@(posedge SYS_CLK_IN) disable iff (SYS_RST_IN) // RULE21
        wr_a_dir && !a_alt_q[2] && !wr_a_alt |=> BANK_A_PIN_OE_OUT[2] == !$past(SFR_REQ_IN.wdata[2]))
        else $error("direction write late");
endmodule
`default_nettype wire

/* rtl/dgp_strobe.sv */
`timescale 1ns/1ps
`default_nettype none
module dgp_strobe
    import dgp_pkg::*;
(
    input  wire logic clk_in,
    input  wire logic rst_in,
    output var  logic tick_out
);
    logic [1:0] cnt_q;
    logic [1:0] cnt_d;

    assign cnt_d = (cnt_q == CNT_DIV_LAST) ? 2'h0 : 2'(cnt_q + 2'h1);

    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            cnt_q    <= 2'h0;
            tick_out <= 1'b0;
        end
        else
        begin
            cnt_q    <= cnt_d;
            tick_out <= (cnt_q == CNT_DIV_LAST);
        end
    end
endmodule
`default_nettype wire

/* rtl/dgp_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module dgp_sync #(
    parameter int unsigned WIDTH = 8
) (
    input  wire logic             clk_in,
    input  wire logic             rst_in,
    input  wire logic [WIDTH-1:0] async_in,
    output var  logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_q;

    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            meta_q   <= '0;
            sync_out <= '0;
        end
        else
        begin
            meta_q   <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule
`default_nettype wire
